// ==== comparator_window_roundrobin_ctrl_tb_top.sv ====
// Purpose: register level tests of cwrc_top
// Assumes: model gives raw level of scan channel
// Notes:   outputs sampled at falling edge
`timescale 1ns/10ps
module comparator_window_roundrobin_ctrl_tb_top
  import cwrc_pkg::*;
;
  logic clk_i = 0, arst_n_i = 0, s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0;
  logic s_arvalid_i = 0, s_rready_i = 0, window_gate_i = 0, ext_trigger_i = 0;
  logic [7:0] s_awaddr_i = 8'h00, s_araddr_i = 8'h00, lvl = 8'h00;
  logic [31:0] s_wdata_i = 32'h0, s_rdata_o, rv;
  logic [3:0] s_wstrb_i = 4'hf;
  logic [1:0] s_bresp_o, s_rresp_o, rr, br;
  logic [2:0] pos_sel_o, neg_sel_o;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic raw_compare_result_i, compare_output_o, irq_o, dma_req_o;
  int error_cnt = 0, checked = 0, cyc = 0, dcnt;
  always #25 clk_i = ~clk_i;
  cwrc_top dut (.clk_i, .arst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
    .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
    .s_rready_i, .raw_compare_result_i, .window_gate_i, .ext_trigger_i, .pos_sel_o,
    .neg_sel_o, .compare_output_o, .irq_o, .dma_req_o);
  cwrc_core_model core (.clk_i, .lvl_i(lvl), .sel_i(pos_sel_o), .dma_req_i(dma_req_o),
    .raw_o(raw_compare_result_i), .dma_cnt_o(dcnt));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // ----------
  // bus tasks, ready seen at falling edge
  // ----------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_awvalid_i && s_awready_o;
      tw = s_wvalid_i && s_wready_o;
      tk = s_bvalid_o;
      br = s_bresp_o;
      @(posedge clk_i);
      if (ta) s_awvalid_i <= 1'b0;
      if (tw) s_wvalid_i <= 1'b0;
      if (tk) s_bready_i <= 1'b0;
    end while (!tk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tk;
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_arvalid_i && s_arready_o;
      tk = s_rvalid_o;
      rv = s_rdata_o;
      rr = s_rresp_o;
      @(posedge clk_i);
      if (ta) s_arvalid_i <= 1'b0;
      if (tk) s_rready_i <= 1'b0;
    end while (!tk);
  endtask
  task automatic trig;
    @(posedge clk_i) ext_trigger_i <= 1'b1;
    tick(2);
    @(posedge clk_i) ext_trigger_i <= 1'b0;
    tick(40);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      chk(rv, 32'h0);
    end
    rd(8'h20);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(8'h24, 32'h1);
    chk(32'(br), 32'(RESP_SLVERR));
    for (int i = 0; i < 8; i++) begin
      wr(CWRC_OFS_MUX, 32'(i * 16 + 7 - i));
      tick(2);
      chk(32'({neg_sel_o, pos_sel_o}), 32'(i * 8 + 7 - i));
    end
    wr(CWRC_OFS_MUX, 32'h0);
    wr(CWRC_OFS_RELOAD, 32'hffff_ffff);
    rd(CWRC_OFS_RELOAD);
    chk(rv, 32'hffff_ffff);
    wr(CWRC_OFS_CTRL, 32'h1);
    wr(CWRC_OFS_IRQ_EN, 32'h1);
    @(posedge clk_i) lvl <= 8'h01;
    tick(5);
    chk(32'(irq_o), 32'h1);
    rd(CWRC_OFS_STATUS);
    chk(rv, 32'h9);
    wr(CWRC_OFS_STATUS, 32'h8);
    rd(CWRC_OFS_STATUS);
    chk(rv, 32'h9);
    wr(CWRC_OFS_STATUS, 32'h1);
    rd(CWRC_OFS_STATUS);
    chk(rv, 32'h8);
    @(posedge clk_i) lvl <= 8'h00;
    tick(5);
    chk(32'(irq_o), 32'h0);
    rd(CWRC_OFS_STATUS);
    chk(rv, 32'h2);
    wr(CWRC_OFS_STATUS, 32'h2);
    wr(CWRC_OFS_CTRL, 32'h9);
    @(posedge clk_i) lvl <= 8'h01;
    tick(5);
    chk(32'(irq_o), 32'h0);
    chk(32'(dcnt), 32'h1);
    wr(CWRC_OFS_STATUS, 32'h7);
    wr(CWRC_OFS_CTRL, 32'h5);
    @(posedge clk_i) window_gate_i <= 1'b1;
    @(posedge clk_i) lvl <= 8'h00;
    tick(3);
    chk(32'(compare_output_o), 32'h0);
    @(posedge clk_i) window_gate_i <= 1'b0;
    @(posedge clk_i) lvl <= 8'h01;
    tick(4);
    chk(32'(compare_output_o), 32'h0);
    wr(CWRC_OFS_CTRL, 32'h155);
    tick(3);
    chk(32'(compare_output_o), 32'h1);
    @(posedge clk_i) lvl <= 8'h00;
    tick(3);
    chk(32'(compare_output_o), 32'h1);
    wr(CWRC_OFS_CTRL, 32'h0);
    @(posedge clk_i) lvl <= 8'ha5;
    wr(CWRC_OFS_PRESET, 32'h0f);
    wr(CWRC_OFS_CTRL, 32'ha01);
    tick(60);
    rd(CWRC_OFS_RESULT);
    chk(rv, 32'h0);
    trig;
    rd(CWRC_OFS_RESULT);
    chk(rv, 32'ha5);
    rd(CWRC_OFS_STATUS);
    chk(rv & 32'h4, 32'h4);
    rd(CWRC_OFS_CHANGED);
    chk(rv, 32'ha5);
    wr(CWRC_OFS_CHANGED, 32'h05);
    rd(CWRC_OFS_CHANGED);
    chk(rv, 32'ha0);
    wr(CWRC_OFS_PRESET, 32'ha5);
    wr(CWRC_OFS_STATUS, 32'h4);
    trig;
    rd(CWRC_OFS_STATUS);
    chk(rv & 32'h4, 32'h0);
    @(posedge clk_i) lvl <= 8'h3c;
    wr(CWRC_OFS_RELOAD, 32'h3);
    wr(CWRC_OFS_CTRL, 32'he01);
    tick(80);
    rd(CWRC_OFS_RESULT);
    chk(rv, 32'h3c);
    close_out;
  end
endmodule // comparator_window_roundrobin_ctrl_tb_top

// ==== cwrc_axil_slave.sv ====
// Purpose: AXI4-Lite slave front end
// Assumes: one write and one read outstanding at most
// Notes:   unmapped addresses answer SLVERR
`timescale 1ns/10ps
module cwrc_axil_slave
  import cwrc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  cwrc_regbus_if.slave     bus
);
  logic aw_have_ff;
  logic w_have_ff;

  assign bus.wr_en   = aw_have_ff & w_have_ff & ~s_bvalid_o;
  assign bus.rd_addr = s_araddr_i;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_awready_o <= 1'b1;
      s_wready_o  <= 1'b1;
      aw_have_ff  <= 1'b0;
      w_have_ff   <= 1'b0;
      bus.wr_addr <= 8'h00;
      bus.wr_data <= 32'h0000_0000;
      bus.wr_strb <= 4'h0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= RESP_OKAY;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        bus.wr_addr <= s_awaddr_i;
        aw_have_ff  <= 1'b1;
        s_awready_o <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        bus.wr_data <= s_wdata_i;
        bus.wr_strb <= s_wstrb_i;
        w_have_ff   <= 1'b1;
        s_wready_o  <= 1'b0;
      end
      if (bus.wr_en) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= bus.wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
      end
      // ready again only after the response is gone
      if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o  <= 1'b0;
        s_awready_o <= 1'b1;
        s_wready_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_arready_o <= 1'b1;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0000_0000;
      s_rresp_o   <= RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b1;
      s_rdata_o   <= bus.rd_data;
      s_rresp_o   <= bus.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end
endmodule // cwrc_axil_slave

// ==== cwrc_core_model.sv ====
// Purpose: comparator core and dma sink
// Assumes: negative side fixed reference
// Notes:   ideal core, no offset
`timescale 1ns/10ps
module cwrc_core_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] lvl_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       dma_req_i,
  output logic            raw_o,
  output int              dma_cnt_o
);
  assign raw_o = lvl_i[sel_i];
  initial dma_cnt_o = 0;
  always @(posedge clk_i) if (dma_req_i) dma_cnt_o <= dma_cnt_o + 1;
endmodule // cwrc_core_model

// ==== cwrc_pkg.sv ====
// Purpose: shared constants for the comparator window / round-robin control block
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz clock
// Notes:   offsets are byte addresses, one aligned word per register
package cwrc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CWRC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CWRC_OFS_MUX     = 8'h04;
  localparam logic [7:0] CWRC_OFS_STATUS  = 8'h08;
  localparam logic [7:0] CWRC_OFS_IRQ_EN  = 8'h0c;
  localparam logic [7:0] CWRC_OFS_RELOAD  = 8'h10;
  localparam logic [7:0] CWRC_OFS_PRESET  = 8'h14;
  localparam logic [7:0] CWRC_OFS_RESULT  = 8'h18;
  localparam logic [7:0] CWRC_OFS_CHANGED = 8'h1c;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTL_EN       = 0;
  localparam int CTL_INV      = 1;
  localparam int CTL_WIN      = 2;
  localparam int CTL_DMA      = 3;
  localparam int CTL_GATE_INV = 4;
  localparam int CTL_EVT_LO   = 5;
  localparam int CTL_FRC_LO   = 7;
  localparam int CTL_RR_EN    = 9;
  localparam int CTL_RR_INT   = 10;
  localparam int CTL_TMR_EN   = 11;
  localparam int MUX_NEG_LO   = 4;
  // status / irq enable bits
  localparam int ST_RISE  = 0;
  localparam int ST_FALL  = 1;
  localparam int ST_RR    = 2;
  localparam int ST_LEVEL = 3;
  localparam logic [31:0] CWRC_CTRL_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_RISE = 2'h1;
  localparam logic [1:0] EVT_FALL = 2'h2;
  localparam logic [1:0] EVT_BOTH = 2'h3;
  localparam logic [1:0] FRC_LOW  = 2'h1;
  localparam logic [1:0] FRC_HIGH = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_KHZ        = 20000;
  localparam int RR_SETTLE_NS   = 100;
  localparam int RR_SETTLE_CALC = (RR_SETTLE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int RR_SETTLE_CYC  = (RR_SETTLE_CALC < 1) ? 1 : RR_SETTLE_CALC;
  typedef enum logic [2:0] {
    RR_IDLE   = 3'b001,
    RR_SETTLE = 3'b010,
    RR_DONE   = 3'b100
  } cwrc_rr_state_t;
endpackage

// ==== cwrc_props.sv ====
// Purpose: port checks for cwrc_top
// Assumes: bench writes whole words
// Notes:   control bits shadowed from finished writes
`timescale 1ns/10ps
module cwrc_props
  import cwrc_pkg::*;
#(
  parameter int SELW = 3
) (
  input wire logic clk_i, arst_n_i, s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o,
  input wire logic s_bvalid_o, s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o,
  input wire logic raw_compare_result_i, window_gate_i, compare_output_o, dma_req_o,
  input wire logic [7:0] s_awaddr_i,
  input wire logic [31:0] s_wdata_i,
  input wire logic [SELW-1:0] pos_sel_o, neg_sel_o
);
  logic [7:0]  ad_ff;
  logic [31:0] wd_ff, ctl_ff;
  logic        idle, gopen;
  assign idle = s_awready_o && s_wready_o;
  assign gopen = window_gate_i ^ ctl_ff[CTL_GATE_INV];
  // ----------
  // shadow, lags the real register by one cycle
  // ----------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ad_ff <= 8'h00;
      wd_ff <= 32'h0;
      ctl_ff <= CWRC_CTRL_RST;
    end else begin
      if (s_awvalid_i && s_awready_o) ad_ff <= s_awaddr_i;
      if (s_wvalid_i && s_wready_o) wd_ff <= s_wdata_i;
      if (s_bvalid_o && s_bready_i && ad_ff == CWRC_OFS_CTRL) ctl_ff <= wd_ff;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_quiet;
    idle && $past(idle) && ctl_ff[CTL_EN] && ctl_ff[CTL_WIN] && ctl_ff[6:5] == EVT_NONE;
  endsequence
  sequence s_wtake;
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
  endsequence
  property p_win_smp;
    s_quiet ##0 (gopen && $stable(window_gate_i))
      |=> compare_output_o == $past(raw_compare_result_i ^ ctl_ff[CTL_INV]);
  endproperty
  property p_win_hold;
    s_quiet ##0 (!gopen && $stable(window_gate_i)) |=> $stable(compare_output_o);
  endproperty
  property p_mux;
    s_bvalid_o && s_bready_i && ad_ff == CWRC_OFS_MUX |=> neg_sel_o == wd_ff[6:4]
      && (ctl_ff[CTL_RR_EN] || pos_sel_o == wd_ff[2:0]);
  endproperty
  property p_dma_pls;
    dma_req_o && $stable(compare_output_o) |=> !dma_req_o;
  endproperty
  property p_dma_mode;
    dma_req_o |-> ctl_ff[CTL_DMA];
  endproperty
  property p_wr_ans;
    s_wtake |-> ##[1:2] s_bvalid_o;
  endproperty
  property p_rd_ans;
    s_arvalid_i && s_arready_o |=> s_rvalid_o && !s_arready_o;
  endproperty
  property p_b_stand;
    s_bvalid_o |-> !s_awready_o && !s_wready_o;
  endproperty
  a_win_smp: assert property (p_win_smp) else $error("window sample");
  a_win_hold: assert property (p_win_hold) else $error("window hold");
  a_mux: assert property (p_mux) else $error("mux select");
  a_dma_pls: assert property (p_dma_pls) else $error("dma pulse");
  a_dma_mode: assert property (p_dma_mode) else $error("dma off");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer");
  a_b_stand: assert property (p_b_stand) else $error("write ready");
endmodule // cwrc_props
bind cwrc_top cwrc_props #(.SELW(SELW)) u_props (.clk_i, .arst_n_i, .s_awvalid_i,
  .s_awready_o, .s_wvalid_i, .s_wready_o, .s_bvalid_o, .s_bready_i, .s_arvalid_i,
  .s_arready_o, .s_rvalid_o, .raw_compare_result_i, .window_gate_i, .compare_output_o,
  .dma_req_o, .s_awaddr_i, .s_wdata_i, .pos_sel_o, .neg_sel_o);

// ==== cwrc_regbus_if.sv ====
// Purpose: internal register access path between bus slave and core
// Assumes: single clock domain
// Notes:   wr_en is a one-cycle pulse, read data is combinational
`timescale 1ns/10ps
interface cwrc_regbus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_ok, rd_data, rd_ok);
  modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface

// ==== cwrc_rr_timer.sv ====
// Purpose: reload timer pacing the round-robin scan
// Assumes: reload sampled when the count expires
// Notes:   reload of zero ticks every cycle
`timescale 1ns/10ps
module cwrc_rr_timer #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         enable_i,
  input  wire logic [W-1:0] reload_i,
  output logic              tick_o
);
  logic [W-1:0] count_ff;

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_ff <= '0;
      tick_o   <= 1'b0;
    end else if (!enable_i) begin
      count_ff <= reload_i;
      tick_o   <= 1'b0;
    end else if (count_ff == '0) begin
      count_ff <= reload_i;
      tick_o   <= 1'b1;
    end else begin
      count_ff <= count_ff - 1'b1;
      tick_o   <= 1'b0;
    end
  end
endmodule // cwrc_rr_timer

// ==== cwrc_top.sv ====
// Purpose: digital control around a low-power comparator: window, scan, events
// Assumes: comparator result and triggers synchronous to clk_i
// Notes:   analog core, dac, hysteresis and filter live outside
//
// Overview of operation
// - in window mode with gate high, output resamples inverted-or-not result each clock until a close event.
// - in window mode with gate low, output holds the last latched value.
// - without dma, enabled rising or falling events raise the processor interrupt.
// - with dma and event enabled, edges raise a dma request instead.
// - positive and negative selects each cover channels 0..7 independently.
// - scan timer takes any 32-bit reload value, zero to all ones.
// - timer enable acts only with internal trigger selected.
// - one preset bit per channel, all written at once from a mask.
// - latest scan result of every channel readable as one bit vector.
// - per-channel changed flags, any subset cleared by one masked write.
// - gate inversion; close event and forced value apply only in window mode.
// - scan event flag sets when any result differs from its preset bit.
// - close event choice: none, rising, falling or both edges.
// - output level status bit is read-only, ignores write-one-to-clear.
`timescale 1ns/10ps
module cwrc_top
  import cwrc_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int SELW = 3
) (
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  input  wire logic [7:0]      s_awaddr_i,
  input  wire logic            s_awvalid_i,
  output logic                 s_awready_o,
  input  wire logic [31:0]     s_wdata_i,
  input  wire logic [3:0]      s_wstrb_i,
  input  wire logic            s_wvalid_i,
  output logic                 s_wready_o,
  output logic [1:0]           s_bresp_o,
  output logic                 s_bvalid_o,
  input  wire logic            s_bready_i,
  input  wire logic [7:0]      s_araddr_i,
  input  wire logic            s_arvalid_i,
  output logic                 s_arready_o,
  output logic [31:0]          s_rdata_o,
  output logic [1:0]           s_rresp_o,
  output logic                 s_rvalid_o,
  input  wire logic            s_rready_i,
  input  wire logic            raw_compare_result_i,
  input  wire logic            window_gate_i,
  input  wire logic            ext_trigger_i,
  output logic [SELW-1:0]      pos_sel_o,
  output logic [SELW-1:0]      neg_sel_o,
  output logic                 compare_output_o,
  output logic                 irq_o,
  output logic                 dma_req_o
);
  cwrc_regbus_if bus ();

  logic [31:0]     ctrl_ff;
  logic [SELW-1:0] pos_ch_ff;
  logic [SELW-1:0] neg_ch_ff;
  logic [2:0]      status_ff;
  logic [2:0]      irq_en_ff;
  logic [31:0]     reload_ff;
  logic [NCH-1:0]  preset_ff;
  logic [NCH-1:0]  result_ff;
  logic [NCH-1:0]  changed_ff;
  logic            raw_prev_ff;
  logic            out_prev_ff;
  logic            closed_ff;
  logic            ext_prev_ff;
  logic [SELW-1:0] ch_ff;
  logic [7:0]      settle_ff;
  cwrc_rr_state_t  rr_state_ff;
  logic            rr_evt_ff;

  logic [31:0]     wmask;
  logic [31:0]     wval;
  logic            raw_compare_result;
  logic            gate;
  logic            close_evt;
  logic            rise_evt;
  logic            fall_evt;
  logic            trig;
  logic            tmr_tick;
  logic            rr_sample;
  logic [1:0]      evt_sel;
  logic [1:0]      frc_val;

  // ----------------------------------------------------------------
  // bus front end and scan timer
  // ----------------------------------------------------------------
  cwrc_axil_slave u_slave (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .s_awaddr_i  (s_awaddr_i),
    .s_awvalid_i (s_awvalid_i),
    .s_awready_o (s_awready_o),
    .s_wdata_i   (s_wdata_i),
    .s_wstrb_i   (s_wstrb_i),
    .s_wvalid_i  (s_wvalid_i),
    .s_wready_o  (s_wready_o),
    .s_bresp_o   (s_bresp_o),
    .s_bvalid_o  (s_bvalid_o),
    .s_bready_i  (s_bready_i),
    .s_araddr_i  (s_araddr_i),
    .s_arvalid_i (s_arvalid_i),
    .s_arready_o (s_arready_o),
    .s_rdata_o   (s_rdata_o),
    .s_rresp_o   (s_rresp_o),
    .s_rvalid_o  (s_rvalid_o),
    .s_rready_i  (s_rready_i),
    .bus         (bus.slave)
  );

  cwrc_rr_timer #(.W(32)) u_timer (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .enable_i (ctrl_ff[CTL_RR_EN] & ctrl_ff[CTL_RR_INT] & ctrl_ff[CTL_TMR_EN]),
    .reload_i (reload_ff),
    .tick_o   (tmr_tick)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wmask = {{8{bus.wr_strb[3]}}, {8{bus.wr_strb[2]}},
                  {8{bus.wr_strb[1]}}, {8{bus.wr_strb[0]}}};
  assign wval  = bus.wr_data & wmask;

  always_comb begin
    case (bus.wr_addr)
      CWRC_OFS_CTRL, CWRC_OFS_MUX, CWRC_OFS_STATUS, CWRC_OFS_IRQ_EN,
      CWRC_OFS_RELOAD, CWRC_OFS_PRESET, CWRC_OFS_RESULT,
      CWRC_OFS_CHANGED: bus.wr_ok = 1'b1;
      default:          bus.wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    bus.rd_ok   = 1'b1;
    bus.rd_data = 32'h0000_0000;
    case (bus.rd_addr)
      CWRC_OFS_CTRL:    bus.rd_data = ctrl_ff;
      CWRC_OFS_MUX:     bus.rd_data[MUX_NEG_LO +: SELW] = neg_ch_ff;
      CWRC_OFS_STATUS:  bus.rd_data[ST_LEVEL:0] = {compare_output_o, status_ff};
      CWRC_OFS_IRQ_EN:  bus.rd_data[ST_RR:0] = irq_en_ff;
      CWRC_OFS_RELOAD:  bus.rd_data = reload_ff;
      CWRC_OFS_PRESET:  bus.rd_data[NCH-1:0] = preset_ff;
      CWRC_OFS_RESULT:  bus.rd_data[NCH-1:0] = result_ff;
      CWRC_OFS_CHANGED: bus.rd_data[NCH-1:0] = changed_ff;
      default:          bus.rd_ok = 1'b0;
    endcase
    if (bus.rd_addr == CWRC_OFS_MUX) begin
      bus.rd_data[SELW-1:0] = pos_ch_ff;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff   <= CWRC_CTRL_RST;
      pos_ch_ff <= '0;
      neg_ch_ff <= '0;
      irq_en_ff <= 3'h0;
      reload_ff <= 32'h0000_0000;
      preset_ff <= '0;
    end else if (bus.wr_en) begin
      case (bus.wr_addr)
        CWRC_OFS_CTRL:   ctrl_ff <= (ctrl_ff & ~wmask) | wval;
        CWRC_OFS_MUX: begin
          if (bus.wr_strb[0]) begin
            pos_ch_ff <= bus.wr_data[SELW-1:0];
            neg_ch_ff <= bus.wr_data[MUX_NEG_LO +: SELW];
          end
        end
        CWRC_OFS_IRQ_EN: if (bus.wr_strb[0]) irq_en_ff <= bus.wr_data[ST_RR:0];
        CWRC_OFS_RELOAD: reload_ff <= (reload_ff & ~wmask) | wval;
        CWRC_OFS_PRESET: if (bus.wr_strb[0]) preset_ff <= bus.wr_data[NCH-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // window path
  // ----------------------------------------------------------------
  assign raw_compare_result = raw_compare_result_i ^ ctrl_ff[CTL_INV];
  assign gate     = window_gate_i ^ ctrl_ff[CTL_GATE_INV];
  assign evt_sel  = ctrl_ff[CTL_EVT_LO +: 2];
  assign frc_val  = ctrl_ff[CTL_FRC_LO +: 2];

  always_comb begin
    case (evt_sel)
      EVT_RISE: close_evt = raw_compare_result & ~raw_prev_ff;
      EVT_FALL: close_evt = ~raw_compare_result & raw_prev_ff;
      EVT_BOTH: close_evt = raw_compare_result ^ raw_prev_ff;
      default:  close_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      raw_prev_ff <= 1'b0;
      closed_ff   <= 1'b0;
    end else begin
      raw_prev_ff <= raw_compare_result;
      if (!ctrl_ff[CTL_WIN] || !gate) begin
        closed_ff <= 1'b0;
      end else if (close_evt) begin
        closed_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      compare_output_o <= 1'b0;
    end else if (!ctrl_ff[CTL_EN]) begin
      compare_output_o <= 1'b0;
    end else if (!ctrl_ff[CTL_WIN]) begin
      compare_output_o <= raw_compare_result;
    end else if (closed_ff) begin
      if (frc_val == FRC_LOW) begin
        compare_output_o <= 1'b0;
      end else if (frc_val == FRC_HIGH) begin
        compare_output_o <= 1'b1;
      end
    end else if (gate) begin
      compare_output_o <= raw_compare_result;
    end
    // gate low holds by falling through
  end

  // ----------------------------------------------------------------
  // events, status, interrupt and dma
  // ----------------------------------------------------------------
  assign rise_evt = compare_output_o & ~out_prev_ff;
  assign fall_evt = ~compare_output_o & out_prev_ff;

  // sticky until write one, set wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_prev_ff <= 1'b0;
      status_ff   <= 3'h0;
    end else begin
      out_prev_ff <= compare_output_o;
      status_ff   <= (status_ff & ~((bus.wr_en && bus.wr_addr == CWRC_OFS_STATUS)
                                    ? wval[ST_RR:0] : 3'h0))
                     | {rr_evt_ff, fall_evt, rise_evt};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o     <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      irq_o     <= (|(status_ff[ST_FALL:ST_RISE] & irq_en_ff[ST_FALL:ST_RISE])
                    & ~ctrl_ff[CTL_DMA])
                   | (status_ff[ST_RR] & irq_en_ff[ST_RR]);
      dma_req_o <= ctrl_ff[CTL_DMA]
                   & |({fall_evt, rise_evt} & irq_en_ff[ST_FALL:ST_RISE]);
    end
  end

  // ----------------------------------------------------------------
  // round-robin scan
  // ----------------------------------------------------------------
  // trigger source choice
  assign trig      = ctrl_ff[CTL_RR_INT] ? tmr_tick : (ext_trigger_i & ~ext_prev_ff);
  assign rr_sample = (rr_state_ff == RR_SETTLE) && (settle_ff == 8'h01);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rr_state_ff <= RR_IDLE;
      ch_ff       <= '0;
      settle_ff   <= 8'h00;
      ext_prev_ff <= 1'b0;
      rr_evt_ff   <= 1'b0;
    end else begin
      ext_prev_ff <= ext_trigger_i;
      rr_evt_ff   <= 1'b0;
      case (rr_state_ff)
        RR_IDLE: begin
          if (trig && ctrl_ff[CTL_RR_EN] && ctrl_ff[CTL_EN]) begin
            ch_ff       <= '0;
            settle_ff   <= 8'(RR_SETTLE_CYC);
            rr_state_ff <= RR_SETTLE;
          end
        end
        RR_SETTLE: begin
          if (!ctrl_ff[CTL_RR_EN]) begin
            rr_state_ff <= RR_IDLE;
          end else if (rr_sample) begin
            if (ch_ff == SELW'(NCH - 1)) begin
              rr_state_ff <= RR_DONE;
            end else begin
              ch_ff     <= ch_ff + 1'b1;
              settle_ff <= 8'(RR_SETTLE_CYC);
            end
          end else begin
            settle_ff <= settle_ff - 8'h01;
          end
        end
        RR_DONE: begin
          rr_evt_ff   <= |(result_ff ^ preset_ff);
          rr_state_ff <= RR_IDLE;
        end
        default: rr_state_ff <= RR_IDLE;
      endcase
    end
  end

  // per-channel result and changed flag
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic hit;
    logic clr;
    assign hit = rr_sample && (ch_ff == SELW'(i));
    assign clr = bus.wr_en && (bus.wr_addr == CWRC_OFS_CHANGED) && wval[i];
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        result_ff[i]  <= 1'b0;
        changed_ff[i] <= 1'b0;
      end else begin
        if (hit) begin
          result_ff[i] <= raw_compare_result;
        end
        changed_ff[i] <= (changed_ff[i] & ~clr) | (hit & (raw_compare_result ^ result_ff[i]));
      end
    end
  end

  // scan steps the positive side, negative stays fixed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_sel_o <= '0;
      neg_sel_o <= '0;
    end else begin
      pos_sel_o <= (rr_state_ff == RR_SETTLE) ? ch_ff : pos_ch_ff;
      neg_sel_o <= neg_ch_ff;
    end
  end
endmodule // cwrc_top
